/* File: event_routing_pkg.sv */
// constants for the event routing network: channel, generator and user codes
// assumes one peripheral clock; generator inputs come straight from the peripherals
package event_routing_pkg;
  localparam int NUM_CHAN = 6;
  localparam int CSEL_W   = 5;
  localparam int NUM_GEN  = 31;
  localparam int USEL_W   = 3;
  localparam int CHAN_EXT = 8;
  localparam int NUM_USER = 20;
  localparam int EVOUT_W  = 2;
  localparam int SYNC_STAGES = 2;

  // generator select codes; the code equals the generator's input bit
  localparam logic [CSEL_W-1:0] SEL_OFF        = 5'h00;
  localparam logic [CSEL_W-1:0] SEL_TAP_8192   = 5'h01;
  localparam logic [CSEL_W-1:0] SEL_TAP_64     = 5'h08;
  localparam logic [CSEL_W-1:0] SEL_LUT0       = 5'h09;
  localparam logic [CSEL_W-1:0] SEL_COMPARATOR = 5'h0d;
  localparam logic [CSEL_W-1:0] SEL_ZERO_CROSS = 5'h0e;
  localparam logic [CSEL_W-1:0] SEL_PIN0       = 5'h0f;
  localparam logic [CSEL_W-1:0] SEL_CONV_DONE  = 5'h17;
  localparam logic [CSEL_W-1:0] SEL_BAUD_CLOCK = 5'h18;
  localparam logic [CSEL_W-1:0] SEL_SPI_CLOCK  = 5'h19;
  localparam logic [CSEL_W-1:0] SEL_TCA_WRAP   = 5'h1a;
  localparam logic [CSEL_W-1:0] SEL_TCA_CMP0   = 5'h1b;
  localparam logic [CSEL_W-1:0] SEL_TCB_CAPTURE_INPUT   = 5'h1e;
  localparam logic [CSEL_W-1:0] SEL_TCB_WRAP   = 5'h1f;
  // codes 0x01..0x16 are asynchronous sources (taps, tables, comparator, detector, pins)
  localparam logic [NUM_GEN:0]  GEN_ASYNC      = 32'h007f_fffe;

  // user indices
  localparam int U_LUT0    = 0;
  localparam int U_PIN0    = 8;
  localparam int U_PIN1    = 9;
  localparam int U_ADC     = 10;
  localparam int U_OP_EN   = 11;
  localparam int U_OP_DIS  = 12;
  localparam int U_OP_DUMP = 13;
  localparam int U_OP_DRV  = 14;
  localparam int U_COUNT_INPUT_A    = 15;
  localparam int U_RESTART = 16;
  localparam int U_CAPTURE_INPUT    = 17;
  localparam int U_FAULT_A = 18;
  localparam int U_FAULT_B = 19;

  typedef enum logic [1:0] {
    CNT_POS  = 2'b00,
    CNT_ANY  = 2'b01,
    CNT_HIGH = 2'b10,
    CNT_DIR  = 2'b11
  } count_mode_type;

  typedef enum logic [1:0] {
    RST_POS  = 2'b00,
    RST_ANY  = 2'b01,
    RST_HIGH = 2'b10,
    RST_DIR  = 2'b11
  } restart_mode_type;
endpackage

/* File: event_sync_cell.sv */
// two-stage synchronizer for a vector of asynchronous levels
// assumes inputs may change at any time; first stage feeds only the second
`timescale 1ns/1ps
module event_sync_cell #(
  parameter int W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce_i) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule

/* File: event_routing_network.sv */
// six-channel event routing network with per-user channel selectors
// assumes generators and users share mclk_i except the asynchronous sources
`timescale 1ns/1ps
module event_routing_network
  import event_routing_pkg::*;
(
  input  wire logic                                mclk_i,
  input  wire logic                                rstn_i,
  input  wire logic                                ce_i,
  input  wire logic [NUM_GEN:1]                    gen_event_i,
  input  wire logic [NUM_CHAN-1:0][CSEL_W-1:0]     channel_source_select_i,
  input  wire logic [NUM_USER-1:0][USEL_W-1:0]     user_channel_select_i,
  input  wire logic [NUM_CHAN-1:0]                 software_event_strobe_i,
  input  wire count_mode_type                      count_input_a_mode_i,
  input  wire restart_mode_type                    restart_input_mode_i,
  output logic      [NUM_USER-1:0]                 user_async_o,
  output logic      [NUM_USER-1:0]                 user_sync_o,
  output logic      [EVOUT_W-1:0]                  event_pin_out_o,
  output logic                                     tca_count_step_o,
  output logic                                     tca_count_down_o,
  output logic                                     tca_restart_o,
  output logic                                     capture_edge_o,
  output logic                                     opamp_disable_o,
  output logic                                     opamp_dump_o,
  output logic                                     opamp_drive_o
);
  logic [NUM_CHAN-1:0][CSEL_W-1:0] chan_sel_q;
  logic [NUM_CHAN-1:0][CSEL_W-1:0] chan_sel_d;
  logic [NUM_CHAN-1:0]             sw_q;
  logic [NUM_CHAN-1:0]             sw_d;
  logic [NUM_CHAN-1:0]             chan_sync_q;
  logic [NUM_CHAN-1:0]             chan_sync_d;
  logic [NUM_CHAN-1:0]             sync_base;
  logic [NUM_CHAN-1:0]             chan_async;
  logic [NUM_USER-1:0]             user_sync_q;
  logic [NUM_USER-1:0]             user_sync_d;
  logic [NUM_GEN:1]                gen_synced;
  logic [NUM_GEN:0]                gen_ext;
  logic [NUM_GEN:0]                gen_sync_ext;
  logic [CHAN_EXT-1:0]             async_ext;
  logic [CHAN_EXT-1:0]             sync_ext;
  logic                            step_q;
  logic                            step_d;
  logic                            down_q;
  logic                            down_d;
  logic                            restart_q;
  logic                            restart_d;
  logic                            capture_input_q;
  logic                            capture_input_d;
  logic                            dis_q;
  logic                            dis_d;

  // all generators pass the synchronizer; only asynchronous ones use its output
  event_sync_cell #(
    .W (NUM_GEN)
  ) u_gen_sync (
    .mclk_i  (mclk_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .async_i (gen_event_i),
    .sync_o  (gen_synced)
  );

  assign gen_ext = {gen_event_i, 1'b0};
  genvar g;
  for (g = 1; g <= NUM_GEN; g++) begin : g_gen
    // synchronous sources go straight through, no synchronizer delay
    assign gen_sync_ext[g] = GEN_ASYNC[g] ? gen_synced[g] : gen_event_i[g];
  end
  assign gen_sync_ext[0] = 1'b0;

  genvar c;
  for (c = 0; c < NUM_CHAN; c++) begin : g_chan
    // async subchannel is the selected generator, inverted while the registered strobe sw_q is set
    assign chan_async[c] = gen_ext[chan_sel_q[c]] ^ sw_q[c];
    assign sync_base[c]  = gen_sync_ext[chan_sel_q[c]];
  end

  assign async_ext = {{(CHAN_EXT-NUM_CHAN-1){1'b0}}, chan_async, 1'b0};
  assign sync_ext  = {{(CHAN_EXT-NUM_CHAN-1){1'b0}}, chan_sync_d, 1'b0};

  genvar u;
  for (u = 0; u < NUM_USER; u++) begin : g_user
    // selector codes 0 and 7 listen to nothing, code n (1..6) to channel n-1
    assign user_async_o[u] = async_ext[user_channel_select_i[u]];
    assign user_sync_d[u]  = sync_ext[user_channel_select_i[u]];
  end

  // combinational on purpose: pin forwarding must work with the clock stopped
  assign event_pin_out_o = {user_async_o[U_PIN1], user_async_o[U_PIN0]};

  always_comb begin
    chan_sel_d  = channel_source_select_i;
    sw_d        = software_event_strobe_i;
    // strobe inverts the clocked channel for as many cycles as it is held high
    chan_sync_d = sync_base ^ software_event_strobe_i;
    step_d      = 1'b0;
    down_d      = 1'b0;
    restart_d   = 1'b0;
    case (count_input_a_mode_i)
      CNT_POS:  step_d = user_sync_d[U_COUNT_INPUT_A] & ~user_sync_q[U_COUNT_INPUT_A];
      CNT_ANY:  step_d = user_sync_d[U_COUNT_INPUT_A] ^ user_sync_q[U_COUNT_INPUT_A];
      CNT_HIGH: step_d = user_sync_d[U_COUNT_INPUT_A];
      CNT_DIR: begin
        step_d = 1'b1;
        down_d = user_sync_d[U_COUNT_INPUT_A];
      end
      default:  step_d = 1'b0;
    endcase
    case (restart_input_mode_i)
      RST_POS:  restart_d = user_sync_d[U_RESTART] & ~user_sync_q[U_RESTART];
      RST_ANY:  restart_d = user_sync_d[U_RESTART] ^ user_sync_q[U_RESTART];
      RST_HIGH: restart_d = user_sync_d[U_RESTART];
      RST_DIR:  down_d    = down_d | user_sync_d[U_RESTART];
      default:  restart_d = 1'b0;
    endcase
    // single-shot may instead use the async subchannel on user_async_o
    capture_input_d = user_sync_d[U_CAPTURE_INPUT] & ~user_sync_q[U_CAPTURE_INPUT];
    // enable stays on the async subchannel, disable is a clocked edge
    dis_d  = user_sync_d[U_OP_DIS] & ~user_sync_q[U_OP_DIS];
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      chan_sel_q  <= '0;
      sw_q        <= '0;
      chan_sync_q <= '0;
      user_sync_q <= '0;
      step_q      <= 1'b0;
      down_q      <= 1'b0;
      restart_q   <= 1'b0;
      capture_input_q      <= 1'b0;
      dis_q       <= 1'b0;
    end else if (ce_i) begin
      chan_sel_q  <= chan_sel_d;
      sw_q        <= sw_d;
      chan_sync_q <= chan_sync_d;
      user_sync_q <= user_sync_d;
      step_q      <= step_d;
      down_q      <= down_d;
      restart_q   <= restart_d;
      capture_input_q      <= capture_input_d;
      dis_q       <= dis_d;
    end
  end

  assign user_sync_o      = user_sync_q;
  assign tca_count_step_o = step_q;
  assign tca_count_down_o = down_q;
  assign tca_restart_o    = restart_q;
  assign capture_edge_o   = capture_input_q;
  assign opamp_disable_o  = dis_q;
  assign opamp_dump_o     = user_sync_q[U_OP_DUMP];
  assign opamp_drive_o    = user_sync_q[U_OP_DRV];

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  property p_off_after_reset;
    $past(!rstn_i) |-> (chan_sel_q == '0) && (chan_sync_q == '0);
  endproperty
  a_off_after_reset: assert property (p_off_after_reset) else $error("channel live after reset");

  property p_async_follow;
    (chan_sel_q[1] == SEL_PIN0) && !sw_q[1] |-> chan_async[1] == gen_event_i[SEL_PIN0];
  endproperty
  a_async_follow: assert property (p_async_follow) else $error("async subchannel not following source");

  property p_sync_direct;
    ce_i && (chan_sel_q[0] == SEL_CONV_DONE) && !software_event_strobe_i[0]
      |=> chan_sync_q[0] == $past(gen_event_i[SEL_CONV_DONE]);
  endproperty
  a_sync_direct: assert property (p_sync_direct) else $error("sync source delayed");

  property p_resync;
    (ce_i && (chan_sel_q[1] == SEL_PIN0) && !software_event_strobe_i[1])[*4]
      |-> chan_sync_q[1] == $past(gen_event_i[SEL_PIN0], 3);
  endproperty
  a_resync: assert property (p_resync) else $error("resync delay wrong");

  property p_sw_invert;
    ce_i && software_event_strobe_i[0] |=> chan_sync_q[0] == !$past(sync_base[0]);
  endproperty
  a_sw_invert: assert property (p_sw_invert) else $error("software event did not invert");

  property p_count_pos;
    $past(ce_i) && tca_count_step_o && ($past(count_input_a_mode_i) == CNT_POS)
      |-> user_sync_o[U_COUNT_INPUT_A] && !$past(user_sync_o[U_COUNT_INPUT_A]);
  endproperty
  a_count_pos: assert property (p_count_pos) else $error("count step without rising edge");

  property p_restart_high;
    ce_i && (restart_input_mode_i == RST_HIGH) |=> tca_restart_o == user_sync_o[U_RESTART];
  endproperty
  a_restart_high: assert property (p_restart_high) else $error("restart not following level");

  property p_capture_edge;
    $past(ce_i) && capture_edge_o |-> user_sync_o[U_CAPTURE_INPUT] && !$past(user_sync_o[U_CAPTURE_INPUT]);
  endproperty
  a_capture_edge: assert property (p_capture_edge) else $error("capture without rising edge");

  property p_opamp_disable;
    $past(ce_i) && opamp_disable_o |-> user_sync_o[U_OP_DIS] && !$past(user_sync_o[U_OP_DIS]);
  endproperty
  a_opamp_disable: assert property (p_opamp_disable) else $error("disable without edge");

  property p_pin_out;
    (user_channel_select_i[U_PIN0] == 3'h2) |-> event_pin_out_o[0] == chan_async[1];
  endproperty
  a_pin_out: assert property (p_pin_out) else $error("pin output not channel 1");

  property p_user_sel;
    (user_channel_select_i[U_PIN1] == 3'h0) |-> !user_async_o[U_PIN1];
  endproperty
  a_user_sel: assert property (p_user_sel) else $error("unselected user sees event");
endmodule

/* File: event_gen_model.sv */
// behavioural model of the peripherals that produce events
// assumes the bench raises requests just after a rising edge of mclk_i
`timescale 1ns/1ps
module event_gen_model
  import event_routing_pkg::*;
(
  input  wire logic             conv_fire_i,
  input  wire logic             baud_level_i,
  input  wire logic             pin_level_i,
  output logic      [NUM_GEN:1] gen_event_o
);
  logic pin_q = 1'b0;

  // a pad moves between clock edges, not on them
  always @(pin_level_i) pin_q <= #30 pin_level_i;

  always_comb begin
    gen_event_o                 = '0;
    gen_event_o[SEL_PIN0]       = pin_q;
    gen_event_o[SEL_CONV_DONE]  = conv_fire_i;
    gen_event_o[SEL_BAUD_CLOCK] = baud_level_i;
  end
endmodule

/* File: event_routing_network_bench.sv */
// self-checking bench for the event routing network
// assumes one 10 MHz clock; generators come from event_gen_model
`timescale 1ns/1ps
module event_routing_network_bench
  import event_routing_pkg::*;
;
  logic                            mclk_i = 1'b0;
  logic                            rstn_i = 1'b0;
  logic                            ce = 1'b1;
  logic [NUM_CHAN-1:0][CSEL_W-1:0] chan_sel = '0;
  logic [NUM_USER-1:0][USEL_W-1:0] user_sel = '0;
  logic [NUM_CHAN-1:0]             sw_strobe = '0;
  count_mode_type                  cnt_mode = CNT_POS;
  restart_mode_type                rst_mode = RST_POS;
  logic                            conv_fire = 1'b0;
  logic                            baud_level = 1'b0;
  logic                            pin_level = 1'b0;
  logic [NUM_GEN:1]                gen_event;
  logic [NUM_USER-1:0]             user_async_o;
  logic [NUM_USER-1:0]             user_sync_o;
  logic [EVOUT_W-1:0]              event_pin_out_o;
  logic                            step_o, down_o, restart_o, capture_input_o, dis_o, dump_o, drive_o;
  int                              bad_count = 0;
  int                              compares = 0;

  always #50 mclk_i = ~mclk_i;

  event_gen_model i_gen (.conv_fire_i(conv_fire), .baud_level_i(baud_level), .pin_level_i(pin_level),
                         .gen_event_o(gen_event));

  event_routing_network i_dut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce), .gen_event_i(gen_event),
    .channel_source_select_i(chan_sel), .user_channel_select_i(user_sel),
    .software_event_strobe_i(sw_strobe), .count_input_a_mode_i(cnt_mode),
    .restart_input_mode_i(rst_mode), .user_async_o(user_async_o), .user_sync_o(user_sync_o),
    .event_pin_out_o(event_pin_out_o), .tca_count_step_o(step_o), .tca_count_down_o(down_o),
    .tca_restart_o(restart_o), .capture_edge_o(capture_input_o), .opamp_disable_o(dis_o),
    .opamp_dump_o(dump_o), .opamp_drive_o(drive_o));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // users point at channels that no generator feeds yet
  task automatic t_reset_off;
    @(posedge mclk_i) baud_level <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1 check("users idle async", 32'(user_async_o), 32'h0);
    check("users idle sync", 32'(user_sync_o), 32'h0);
    @(posedge mclk_i) baud_level <= 1'b0;
    chan_sel[0] <= SEL_CONV_DONE;
    chan_sel[1] <= SEL_PIN0;
    chan_sel[2] <= SEL_BAUD_CLOCK;
    repeat (4) @(posedge mclk_i);
  endtask

  task automatic t_sync_pulse;
    @(posedge mclk_i) conv_fire <= 1'b1;
    #1 check("pulse async", 32'(user_async_o[U_ADC]), 32'h1);
    @(posedge mclk_i) conv_fire <= 1'b0;
    #1 check("pulse sync", 32'(user_sync_o[U_ADC]), 32'h1);
    @(posedge mclk_i) #1 check("pulse end", 32'(user_sync_o[U_ADC]), 32'h0);
  endtask

  task automatic t_async_pin;
    @(posedge mclk_i) pin_level <= 1'b1;
    #40 check("pin async", 32'(user_async_o[U_PIN0]), 32'h1);
    check("pin out", 32'(event_pin_out_o), 32'h1);
    check("raw table input", 32'(user_async_o[U_LUT0]), 32'h1);
    check("other pin", 32'(user_async_o[U_PIN1]), 32'h0);
    repeat (2) @(posedge mclk_i);
    #1 check("pin sync early", 32'(user_sync_o[U_PIN0]), 32'h0);
    @(posedge mclk_i) #1 check("pin sync", 32'(user_sync_o[U_PIN0]), 32'h1);
    @(posedge mclk_i) pin_level <= 1'b0;
    repeat (5) @(posedge mclk_i);
    #1 check("pin sync low", 32'(user_sync_o[U_PIN0]), 32'h0);
  endtask

  task automatic t_sw_event;
    @(posedge mclk_i) sw_strobe[0] <= 1'b1;
    @(posedge mclk_i) sw_strobe[0] <= 1'b0;
    #1 check("sw inverted", 32'(user_sync_o[U_ADC]), 32'h1);
    check("sw async inverted", 32'(user_async_o[U_ADC]), 32'h1);
    @(posedge mclk_i) #1 check("sw restored", 32'(user_sync_o[U_ADC]), 32'h0);
  endtask

  // clock enable low: clocked side holds, async side still follows
  task automatic t_freeze;
    @(posedge mclk_i) ce <= 1'b0;
    conv_fire <= 1'b1;
    #1 check("frozen async", 32'(user_async_o[U_ADC]), 32'h1);
    @(posedge mclk_i) conv_fire <= 1'b0;
    #1 check("frozen sync", 32'(user_sync_o[U_ADC]), 32'h0);
    @(posedge mclk_i) ce <= 1'b1;
    @(posedge mclk_i) #1 check("thawed sync", 32'(user_sync_o[U_ADC]), 32'h0);
  endtask

  // one baud level three edges long, seen through every detector mode
  task automatic t_modes;
    int exp_step[4] = '{1, 2, 3, 8};
    int exp_rst[4] = '{1, 2, 3, 0};
    int n_step, n_down, n_rst, n_capture_input, n_dis, n_dump, n_drive;
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk_i) cnt_mode <= count_mode_type'(m);
      rst_mode <= restart_mode_type'(m);
      repeat (2) @(posedge mclk_i);
      {n_step, n_down, n_rst, n_capture_input, n_dis, n_dump, n_drive} = '0;
      baud_level <= 1'b1;
      for (int c = 0; c < 8; c++) begin
        @(posedge mclk_i) if (c == 2) baud_level <= 1'b0;
        #1;
        n_step += int'(step_o === 1'b1);
        n_down += int'(down_o === 1'b1);
        n_rst += int'(restart_o === 1'b1);
        n_capture_input += int'(capture_input_o === 1'b1);
        n_dis += int'(dis_o === 1'b1);
        n_dump += int'(dump_o === 1'b1);
        n_drive += int'(drive_o === 1'b1);
      end
      check("count steps", n_step, exp_step[m]);
      check("count down", n_down, (m == 3) ? 3 : 0);
      check("restarts", n_rst, exp_rst[m]);
      check("captures", n_capture_input, 1);
      check("opamp disable", n_dis, 1);
      check("opamp dump", n_dump, 3);
      check("opamp drive", n_drive, 3);
    end
  endtask

  initial begin
    #300000;
    bad_count++;
    print_verdict;
  end

  initial begin
    @(posedge mclk_i) user_sel[U_ADC] <= 3'h1;
    user_sel[U_PIN0] <= 3'h2;
    user_sel[U_LUT0] <= 3'h2;
    user_sel[U_OP_DIS] <= 3'h3;
    user_sel[U_OP_DUMP] <= 3'h3;
    user_sel[U_OP_DRV] <= 3'h3;
    user_sel[U_COUNT_INPUT_A] <= 3'h3;
    user_sel[U_RESTART] <= 3'h3;
    user_sel[U_CAPTURE_INPUT] <= 3'h3;
    repeat (19) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_reset_off;
    t_sync_pulse;
    t_async_pin;
    t_sw_event;
    t_freeze;
    t_modes;
    print_verdict;
  end
endmodule
